// [verilog/sfe_pkg.sv]
package sfe_pkg;

  localparam int ADDR_W       = 20;
  localparam int PAGE_W       = 12;
  localparam int OFF_W        = 8;
  localparam int PAGE_COUNT   = 4096;
  localparam int PAGE_BYTES   = 256;
  localparam int SECTOR_COUNT = 256;
  localparam int BLOCK_COUNT  = 16;
  localparam int UID_W        = 64;
  localparam int SEC_AREAS    = 3;
  localparam int LANES        = 4;
  localparam int BYTE_W       = 8;
  localparam int FIFO_DEPTH   = 8;

  localparam logic [ADDR_W-1:0] MASK_SECTOR  = 20'h00FFF;
  localparam logic [ADDR_W-1:0] MASK_BLK32   = 20'h07FFF;
  localparam logic [ADDR_W-1:0] MASK_BLK64   = 20'h0FFFF;
  localparam logic [ADDR_W-1:0] MASK_CHIP    = 20'hFFFFF;
  localparam logic [OFF_W-1:0]  PAGE_LAST    = 8'hFF;
  localparam logic [8:0]        PAGE_BYTES_C = 9'h100;
  localparam logic [BYTE_W-1:0] IDLE_BYTE    = 8'hFF;
  localparam int                SEC_SEL_LSB  = 12;
  localparam int                SEC_ZERO_LSB = 14;

  // Arbitrary neutral serial number
  localparam logic [UID_W-1:0] UID_DEFAULT = 64'h0123_4567_89AB_CDEF;

  typedef enum logic [1:0] {
    SFE_LANE_SINGLE = 2'b00,
    SFE_LANE_DUAL   = 2'b01,
    SFE_LANE_QUAD   = 2'b10
  } sfe_lane_mode_t;

  typedef enum logic [2:0] {
    SFE_OP_PROGRAM  = 3'b000,
    SFE_OP_SECTOR   = 3'b001,
    SFE_OP_BLK32    = 3'b010,
    SFE_OP_BLK64    = 3'b011,
    SFE_OP_CHIP     = 3'b100,
    SFE_OP_STATUS   = 3'b101
  } sfe_op_t;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [OFF_W-1:0]  offset;
  } sfe_addr_t;

  typedef struct packed {
    sfe_addr_t first;
    sfe_addr_t last;
  } sfe_span_t;

endpackage : sfe_pkg

// [verilog/sfe_front_end.sv]
`timescale 1ns/1ps

module sfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_nxt  = push ? PW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? PW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = (PW+1)'(cnt_r + (PW+1)'(push) - (PW+1)'(pop));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule : sfe_fifo

module sfe_front_end #(
  parameter logic [sfe_pkg::UID_W-1:0] UNIQUE_ID = sfe_pkg::UID_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          cs_n,
  input  wire logic                          spi_clk,
  input  wire logic [sfe_pkg::LANES-1:0]     lane_in,
  output logic      [sfe_pkg::LANES-1:0]     lane_out,
  output logic      [sfe_pkg::LANES-1:0]     lane_oe,
  input  wire sfe_pkg::sfe_lane_mode_t       lane_mode,
  input  wire logic                          drive_en,
  input  wire logic                          four_lane_enable,
  output logic                               selected,
  output logic                               write_protect_n,
  output logic                               rx_valid,
  output logic      [sfe_pkg::BYTE_W-1:0]    rx_data,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [sfe_pkg::BYTE_W-1:0]    tx_data,
  input  wire logic                          op_start,
  input  wire sfe_pkg::sfe_op_t              op_kind,
  input  wire logic [sfe_pkg::ADDR_W-1:0]    op_addr,
  input  wire logic                          op_done,
  output logic                               busy,
  output sfe_pkg::sfe_span_t                 op_span,
  input  wire logic                          prog_step,
  output sfe_pkg::sfe_addr_t                 prog_addr,
  output logic                               prog_full,
  output logic      [sfe_pkg::UID_W-1:0]     unique_id,
  input  wire logic [sfe_pkg::SEC_AREAS-1:0] sec_lock,
  output logic      [1:0]                    sec_area,
  output logic                               sec_write_ok
);

  // Erase or program span around an address
  function automatic sfe_pkg::sfe_span_t span_of(input sfe_pkg::sfe_op_t k,
                                                   input logic [sfe_pkg::ADDR_W-1:0] a);
    logic [sfe_pkg::ADDR_W-1:0] m;
    sfe_pkg::sfe_span_t         s;
    m = '0;
    unique case (k)
      sfe_pkg::SFE_OP_SECTOR: m = sfe_pkg::MASK_SECTOR;
      sfe_pkg::SFE_OP_BLK32:  m = sfe_pkg::MASK_BLK32;
      sfe_pkg::SFE_OP_BLK64:  m = sfe_pkg::MASK_BLK64;
      sfe_pkg::SFE_OP_CHIP:   m = sfe_pkg::MASK_CHIP;
      default:                m = {{sfe_pkg::PAGE_W{1'b0}}, sfe_pkg::PAGE_LAST};
    endcase
    s.first = (k == sfe_pkg::SFE_OP_PROGRAM) ? a : (a & ~m);
    s.last  = a | m;
    return s;
  endfunction : span_of

  // Bits moved per clock edge in a lane mode
  function automatic logic [2:0] step_of(input logic quad, input logic dual);
    return quad ? 3'h4 : (dual ? 3'h2 : 3'h1);
  endfunction : step_of

  logic quad_on, dual_on, pause, pause_rx, pause_tx, link_rst_n;

  // Quad needs the enable bit
  assign quad_on = (lane_mode == sfe_pkg::SFE_LANE_QUAD) & four_lane_enable;
  assign dual_on = (lane_mode == sfe_pkg::SFE_LANE_DUAL);
  assign link_rst_n = rst_n & ~cs_n;

  // ---------------- Link domain ----------------
  logic                        hold_r;
  logic [sfe_pkg::BYTE_W-1:0]  rx_sh_r, rx_sh_nxt, rx_byte_r, rx_byte_nxt;
  logic [2:0]                  rx_cnt_r, rx_cnt_nxt;
  logic                        rx_tog_r, rx_tog_nxt;
  logic [sfe_pkg::BYTE_W-1:0]  tx_sh_r, tx_sh_nxt;
  logic [2:0]                  tx_cnt_r, tx_cnt_nxt;
  logic                        ack_tog_r, ack_tog_nxt;
  logic [1:0]                  req_sync_r;
  logic                        tx_req_r, tx_req_nxt;
  logic [sfe_pkg::BYTE_W-1:0]  tx_byte_r, tx_byte_nxt;
  logic [2:0]                  step;

  assign step = step_of(quad_on, dual_on);

  // pause timing
  // Rising edges see the pin as it stood while the clock was low
  assign pause_rx = ~quad_on & ~lane_in[3];
  // Falling edges see the level caught at the last rising edge
  assign pause_tx = ~quad_on & hold_r;
  assign pause    = spi_clk ? pause_tx : pause_rx;

  always_comb begin
    rx_sh_nxt   = rx_sh_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_byte_nxt = rx_byte_r;
    rx_tog_nxt  = rx_tog_r;
    if (!pause_rx) begin
      if (quad_on) begin
        rx_sh_nxt = {rx_sh_r[3:0], lane_in};
      end else if (dual_on) begin
        rx_sh_nxt = {rx_sh_r[5:0], lane_in[1:0]};
      end else begin
        rx_sh_nxt = {rx_sh_r[6:0], lane_in[0]};
      end
      rx_cnt_nxt = 3'(rx_cnt_r + step);
      if (rx_cnt_nxt == 3'h0) begin
        rx_byte_nxt = rx_sh_nxt;
        rx_tog_nxt  = ~rx_tog_r;
      end
    end
  end

  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_sh_r  <= '0;
      rx_cnt_r <= '0;
      hold_r   <= 1'b0;
    end else begin
      rx_sh_r  <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      hold_r   <= ~lane_in[3];
    end
  end

  // Byte and toggle survive deselect for the crossing
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_r <= '0;
      rx_tog_r  <= 1'b0;
    end else begin
      rx_byte_r <= rx_byte_nxt;
      rx_tog_r  <= rx_tog_nxt;
    end
  end

  always_comb begin
    tx_sh_nxt   = tx_sh_r;
    tx_cnt_nxt  = tx_cnt_r;
    ack_tog_nxt = ack_tog_r;
    if (!pause_tx) begin
      if (tx_cnt_r == 3'h0) begin
        if (req_sync_r[1] != ack_tog_r) begin
          tx_sh_nxt   = tx_byte_r;
          ack_tog_nxt = ~ack_tog_r;
        end else begin
          tx_sh_nxt = sfe_pkg::IDLE_BYTE;
        end
      end else begin
        tx_sh_nxt = sfe_pkg::BYTE_W'(tx_sh_r << step);
      end
      tx_cnt_nxt = 3'(tx_cnt_r + step);
    end
  end

  always_ff @(negedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_sh_r  <= sfe_pkg::IDLE_BYTE;
      tx_cnt_r <= '0;
    end else begin
      tx_sh_r  <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  always_ff @(negedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_tog_r  <= 1'b0;
      req_sync_r <= '0;
    end else begin
      ack_tog_r  <= ack_tog_nxt;
      req_sync_r <= {req_sync_r[0], tx_req_r};
    end
  end

  // Output bits straight from the falling-edge shifter
  always_comb begin
    lane_out = '0;
    lane_oe  = '0;
    if (quad_on) begin
      lane_out = tx_sh_r[7:4];
    end else if (dual_on) begin
      lane_out[1:0] = tx_sh_r[7:6];
    end else begin
      lane_out[1] = tx_sh_r[7];
    end
    if (!cs_n && drive_en && !pause) begin
      lane_oe = quad_on ? 4'hF : (dual_on ? 4'h3 : 4'h2);
    end
  end

  // ---------------- Core domain ----------------
  logic [2:0] cs_s_r, rxt_s_r, ack_s_r, wp_s_r;
  logic       cs_hi_r, cs_hi_nxt, armed_r, armed_nxt, rx_seen_r, rx_seen_nxt;
  logic       rx_valid_r, rx_valid_nxt;
  logic [sfe_pkg::BYTE_W-1:0] rx_data_r, rx_data_nxt;
  logic       wp_r, wp_nxt;
  logic       slot_empty, f_valid;
  logic [sfe_pkg::BYTE_W-1:0] f_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_r  <= '0;
      rxt_s_r <= '0;
      ack_s_r <= '0;
      wp_s_r  <= 3'h7;
    end else begin
      cs_s_r  <= {cs_s_r[1:0], cs_n};
      rxt_s_r <= {rxt_s_r[1:0], rx_tog_r};
      ack_s_r <= {ack_s_r[1:0], ack_tog_r};
      wp_s_r  <= {wp_s_r[1:0], lane_in[2]};
    end
  end

  always_comb begin
    cs_hi_nxt    = (cs_s_r[2] == cs_s_r[1]) ? cs_s_r[2] : cs_hi_r;
    armed_nxt    = armed_r | cs_hi_r;
    rx_seen_nxt  = (rxt_s_r[2] == rxt_s_r[1]) ? rxt_s_r[2] : rx_seen_r;
    rx_valid_nxt = 1'b0;
    rx_data_nxt  = rx_data_r;
    if (rx_seen_nxt != rx_seen_r && armed_r) begin
      rx_valid_nxt = 1'b1;
      rx_data_nxt  = rx_byte_r;
    end
    wp_nxt = (wp_s_r[2] == wp_s_r[1]) ? (wp_s_r[2] | quad_on) : wp_r;
    tx_req_nxt  = tx_req_r;
    tx_byte_nxt = tx_byte_r;
    if (slot_empty && f_valid) begin
      tx_req_nxt  = ~tx_req_r;
      tx_byte_nxt = f_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_hi_r    <= 1'b0;
      armed_r    <= 1'b0;
      rx_seen_r  <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r  <= '0;
      wp_r       <= 1'b1;
      tx_req_r   <= 1'b0;
      tx_byte_r  <= sfe_pkg::IDLE_BYTE;
    end else begin
      cs_hi_r    <= cs_hi_nxt;
      armed_r    <= armed_nxt;
      rx_seen_r  <= rx_seen_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_data_r  <= rx_data_nxt;
      wp_r       <= wp_nxt;
      tx_req_r   <= tx_req_nxt;
      tx_byte_r  <= tx_byte_nxt;
    end
  end

  assign slot_empty      = (tx_req_r == ack_s_r[2]) && (ack_s_r[2] == ack_s_r[1]);
  assign selected        = ~cs_hi_r & armed_r;
  assign write_protect_n = wp_r;
  assign rx_valid        = rx_valid_r;
  assign rx_data         = rx_data_r;

  sfe_fifo #(
    .WIDTH (sfe_pkg::BYTE_W),
    .DEPTH (sfe_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (slot_empty),
    .out_data  (f_data)
  );

  // ---------------- Array geometry and operations ----------------
  logic               busy_r, busy_nxt;
  sfe_pkg::sfe_span_t span_r, span_nxt;
  sfe_pkg::sfe_addr_t paddr_r, paddr_nxt;
  logic [8:0]         pcnt_r, pcnt_nxt;

  always_comb begin
    busy_nxt  = op_start | (busy_r & ~op_done);
    span_nxt  = span_r;
    paddr_nxt = paddr_r;
    pcnt_nxt  = pcnt_r;
    if (op_start && !busy_r) begin
      span_nxt  = span_of(op_kind, op_addr);
      paddr_nxt = op_addr;
      pcnt_nxt  = '0;
    end else if (prog_step && pcnt_r != sfe_pkg::PAGE_BYTES_C) begin
      paddr_nxt.offset = sfe_pkg::OFF_W'(paddr_r.offset + 1'b1);
      pcnt_nxt         = 9'(pcnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r  <= 1'b0;
      span_r  <= '0;
      paddr_r <= '0;
      pcnt_r  <= '0;
    end else begin
      busy_r  <= busy_nxt;
      span_r  <= span_nxt;
      paddr_r <= paddr_nxt;
      pcnt_r  <= pcnt_nxt;
    end
  end

  assign busy      = busy_r;
  assign op_span   = span_r;
  assign prog_addr = paddr_r;
  assign prog_full = (pcnt_r == sfe_pkg::PAGE_BYTES_C);
  assign unique_id = UNIQUE_ID;

  always_comb begin
    sec_area     = op_addr[sfe_pkg::SEC_SEL_LSB +: 2];
    sec_write_ok = (sec_area != 2'h0) && (op_addr[sfe_pkg::ADDR_W-1:sfe_pkg::SEC_ZERO_LSB] == '0)
                   && !sec_lock[2'(sec_area - 2'h1)];
  end

endmodule : sfe_front_end

// [dv/sfe_front_end_chk.sv]
`timescale 1ns/1ps

module sfe_chk (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    cs_n,
  input wire logic [3:0]              lane_oe,
  input wire sfe_pkg::sfe_lane_mode_t lane_mode,
  input wire logic                    drive_en,
  input wire logic                    four_lane_enable,
  input wire logic                    selected,
  input wire logic                    rx_valid,
  input wire logic                    op_start,
  input wire sfe_pkg::sfe_op_t        op_kind,
  input wire logic [19:0]             op_addr,
  input wire logic                    op_done,
  input wire logic                    busy,
  input wire sfe_pkg::sfe_span_t      op_span,
  input wire logic                    prog_full
);
  logic [19:0] msk;

  always_comb begin
    case (op_kind)
      sfe_pkg::SFE_OP_SECTOR: msk = sfe_pkg::MASK_SECTOR;
      sfe_pkg::SFE_OP_BLK32:  msk = sfe_pkg::MASK_BLK32;
      sfe_pkg::SFE_OP_BLK64:  msk = sfe_pkg::MASK_BLK64;
      default:                msk = sfe_pkg::MASK_CHIP;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_desel_off;
    cs_n |-> lane_oe == 4'h0;
  endproperty
  a_desel_off: assert property (p_desel_off) else $error("lanes driven while deselected");

  property p_narrow;
    (lane_mode != sfe_pkg::SFE_LANE_QUAD || !four_lane_enable) |-> lane_oe[3:2] == 2'b00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lanes driven outside quad");

  property p_single;
    lane_mode == sfe_pkg::SFE_LANE_SINGLE && !four_lane_enable |-> !lane_oe[0];
  endproperty
  a_single: assert property (p_single) else $error("input lane driven in single mode");

  property p_quad;
    !cs_n && drive_en && four_lane_enable && lane_mode == sfe_pkg::SFE_LANE_QUAD |-> lane_oe == 4'hF;
  endproperty
  a_quad: assert property (p_quad) else $error("quad read not on four lanes");

  property p_sel_gone;
    cs_n [*6] |-> !selected;
  endproperty
  a_sel_gone: assert property (p_sel_gone) else $error("still selected after release");

  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("byte strobe too long");

  property p_busy_set;
    op_start && !busy |=> busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised");

  property p_busy_hold;
    busy && !op_done |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end;
    op_done && !op_start |=> !busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not cleared");

  property p_prog_span;
    op_start && !busy && op_kind == sfe_pkg::SFE_OP_PROGRAM |=>
      op_span == {$past(op_addr), $past(op_addr[19:8]), 8'hFF} && !prog_full;
  endproperty
  a_prog_span: assert property (p_prog_span) else $error("program span wrong");

  property p_erase_span;
    op_start && !busy && op_kind inside {sfe_pkg::SFE_OP_SECTOR, sfe_pkg::SFE_OP_BLK32,
      sfe_pkg::SFE_OP_BLK64, sfe_pkg::SFE_OP_CHIP} |=>
      op_span[39:20] == ($past(op_addr) & ~$past(msk)) && op_span[19:0] == ($past(op_addr) | $past(msk));
  endproperty
  a_erase_span: assert property (p_erase_span) else $error("erase span wrong");
endmodule : sfe_chk

// [dv/sfe_host_model.sv]
`timescale 1ns/1ps

module sfe_host_model (
  output logic            cs_n,
  output logic            spi_clk,
  output logic      [3:0] lanes,
  input  wire logic [3:0] lane_in
);
  logic [0:255] rd;

  initial begin
    cs_n = 1'b1;
    spi_clk = 1'b0;
    lanes = 4'hF;
    rd = '0;
  end

  // 12 ns period, data moves while low
  task automatic pulse;
    #6 spi_clk = 1'b1;
    #6 spi_clk = 1'b0;
  endtask : pulse

  task automatic sel;
    #10 cs_n = 1'b0;
    #10;
  endtask : sel

  task automatic desel;
    #10 cs_n = 1'b1;
    #10;
  endtask : desel

  task automatic pause_line(input logic p);
    lanes[3] = p;
    #10;
  endtask : pause_line

  task automatic protect_line(input logic p);
    lanes[2] = p;
    #10;
  endtask : protect_line

  task automatic send(input int w, input logic [7:0] b);
    for (int i = 0; i < 8; i += w) begin
      if (w == 4) lanes = b[7-i -: 4];
      else if (w == 2) lanes = {2'b11, b[7-i -: 2]};
      else lanes = {2'b11, ~lanes[1], b[7-i]};
      pulse();
    end
    lanes = 4'hF;
  endtask : send

  task automatic read;
    for (int i = 0; i < 256; i++) begin
      #6 spi_clk = 1'b1;
      rd[i] = lane_in[1];
      #6 spi_clk = 1'b0;
    end
  endtask : read
endmodule : sfe_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps

module testbench;
  // Arbitrary serial number
  localparam logic [63:0] UID = 64'h0F1E_2D3C_4B5A_6978;
  logic clk, rst_n, drive_en, four_lane_enable, tx_valid, op_start, op_done, prog_step, cs_n, spi_clk;
  logic selected, write_protect_n, rx_valid, tx_ready, busy, prog_full, sec_write_ok;
  logic [3:0]              lane_in, lane_out, lane_oe, host_lanes;
  logic [7:0]              rx_data, tx_data;
  logic [19:0]             op_addr;
  logic [63:0]             unique_id;
  logic [2:0]              sec_lock;
  logic [1:0]              sec_area;
  sfe_pkg::sfe_lane_mode_t lane_mode;
  sfe_pkg::sfe_op_t        op_kind;
  sfe_pkg::sfe_span_t      op_span;
  sfe_pkg::sfe_addr_t      prog_addr;
  int                      error_cnt, samples_checked;

  always #20 clk = ~clk;
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_lanes);

  sfe_host_model i_host (.cs_n(cs_n), .spi_clk(spi_clk), .lanes(host_lanes), .lane_in(lane_in));

  sfe_front_end #(.UNIQUE_ID(UID)) i_dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .spi_clk(spi_clk), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe(lane_oe), .lane_mode(lane_mode), .drive_en(drive_en), .four_lane_enable(four_lane_enable),
    .selected(selected), .write_protect_n(write_protect_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_done(op_done), .busy(busy), .op_span(op_span), .prog_step(prog_step),
    .prog_addr(prog_addr), .prog_full(prog_full), .unique_id(unique_id), .sec_lock(sec_lock),
    .sec_area(sec_area), .sec_write_ok(sec_write_ok));

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_rx;
    int k;
    for (k = 0; k < 30 && rx_valid !== 1'b1; k++) tick(1);
    if (k == 30) begin
      error_cnt++;
      $display("wrong value at %0t: no byte", $time);
      complete_run();
    end
  endtask : wait_rx

  task automatic t_idle;
    @(posedge clk);
    drive_en <= 1'b1;
    tick(1);
    cmp(lane_oe, 4'h0, "idle oe");
    cmp(selected, 1'b0, "idle sel");
    cmp(unique_id, UID, "uid");
    i_host.protect_line(1'b0);
    tick(5);
    cmp(write_protect_n, 1'b0, "protect low");
    lane_mode        <= sfe_pkg::SFE_LANE_QUAD;
    four_lane_enable <= 1'b1;
    tick(2);
    cmp(write_protect_n, 1'b1, "protect in quad");
    i_host.protect_line(1'b1);
    lane_mode        <= sfe_pkg::SFE_LANE_SINGLE;
    four_lane_enable <= 1'b0;
    tick(5);
    cmp(write_protect_n, 1'b1, "protect high");
  endtask : t_idle

  task automatic t_rx(input sfe_pkg::sfe_lane_mode_t m, input logic fe, input int w, input logic [7:0] b,
                      input logic [3:0] oe);
    @(posedge clk);
    lane_mode <= m;
    four_lane_enable <= fe;
    drive_en <= 1'b0;
    tick(2);
    i_host.sel();
    i_host.send(w, b);
    wait_rx();
    cmp(rx_data, b, "rx byte");
    cmp(selected, 1'b1, "selected");
    i_host.desel();
    @(posedge clk);
    drive_en <= 1'b1;
    tick(2);
    i_host.sel();
    tick(1);
    cmp(lane_oe, oe, "read lanes");
    i_host.desel();
    tick(6);
    cmp(lane_oe, 4'h0, "desel oe");
    cmp(selected, 1'b0, "desel");
  endtask : t_rx

  task automatic t_pause;
    @(posedge clk);
    lane_mode <= sfe_pkg::SFE_LANE_SINGLE;
    four_lane_enable <= 1'b0;
    drive_en <= 1'b1;
    tick(2);
    i_host.sel();
    i_host.pause_line(1'b0);
    tick(1);
    cmp(lane_oe, 4'h0, "paused oe");
    repeat (3) i_host.pulse();
    i_host.pause_line(1'b1);
    tick(1);
    cmp(lane_oe, 4'h2, "resumed oe");
    i_host.send(1, 8'h5A);
    wait_rx();
    cmp(rx_data, 8'h5A, "paused byte");
    i_host.desel();
  endtask : t_pause

  task automatic t_tx;
    int n;
    logic hit;
    logic [7:0] q[$];
    n = 0;
    hit = 1'b0;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= 8'h11;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      if (tx_ready !== 1'b1) break;
      n++;
      tx_data <= tx_data + 8'h11;
    end
    tx_valid <= 1'b0;
    tick(1);
    cmp(tx_ready, 1'b0, "fifo full");
    cmp(n >= sfe_pkg::FIFO_DEPTH, 1'b1, "fifo depth");
    i_host.sel();
    i_host.read();
    i_host.desel();
    for (int off = 0; off < 8 && !hit; off++) begin
      q = {};
      for (int j = off; j + 8 <= 256; j += 8) if (i_host.rd[j +: 8] != 8'hFF) q.push_back(i_host.rd[j +: 8]);
      if (q.size() == n) begin
        hit = 1'b1;
        foreach (q[i]) if (q[i] !== 8'h11 * (i + 1)) hit = 1'b0;
      end
    end
    cmp(hit, 1'b1, "tx stream");
    tick(1);
    cmp(tx_ready, 1'b1, "drained");
  endtask : t_tx

  task automatic op(input sfe_pkg::sfe_op_t k, input logic [19:0] a);
    @(posedge clk);
    op_kind <= k;
    op_addr <= a;
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    tick(1);
  endtask : op

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      prog_step <= 1'b1;
    end
    @(posedge clk);
    prog_step <= 1'b0;
    tick(1);
  endtask : step

  task automatic done;
    @(posedge clk);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    tick(1);
  endtask : done

  task automatic t_ops;
    logic [19:0] m [1:4];
    m = '{sfe_pkg::MASK_SECTOR, sfe_pkg::MASK_BLK32, sfe_pkg::MASK_BLK64, sfe_pkg::MASK_CHIP};
    op(sfe_pkg::SFE_OP_PROGRAM, 20'h123FE);
    cmp(op_span, {20'h123FE, 20'h123FF}, "prog span");
    i_host.sel();
    i_host.desel();
    step(2);
    cmp(busy, 1'b1, "busy deselected");
    cmp(prog_addr, 20'h12300, "page wrap");
    step(254);
    cmp(prog_full, 1'b1, "page full");
    step(1);
    cmp(prog_addr, 20'h123FE, "step ignored");
    op(sfe_pkg::SFE_OP_SECTOR, 20'h45678);
    cmp(op_span, {20'h123FE, 20'h123FF}, "busy refusal");
    done();
    for (int k = 1; k <= 5; k++) begin
      op(sfe_pkg::sfe_op_t'(k), 20'hABCDE);
      cmp(busy, 1'b1, "busy");
      if (k < 5) cmp(op_span, {20'hABCDE & ~m[k], 20'hABCDE | m[k]}, "erase span");
      done();
      cmp(busy, 1'b0, "idle");
    end
  endtask : t_ops

  task automatic t_sec;
    for (int n = 1; n <= 4; n++) begin
      @(posedge clk);
      sec_lock <= 3'b010;
      op_addr <= (n == 4) ? 20'h05000 : 20'(n << 12);
      tick(1);
      cmp(sec_area, (n == 4) ? 2'h1 : n[1:0], "area");
      cmp(sec_write_ok, n != 2 && n != 4, "area lock");
    end
  endtask : t_sec

  task automatic t_rearm;
    int c;
    c = 0;
    @(posedge clk);
    drive_en <= 1'b0;
    rst_n <= 1'b0;
    i_host.sel();
    tick(2);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(5);
    i_host.send(1, 8'hE7);
    repeat (30) begin
      tick(1);
      if (rx_valid === 1'b1) c++;
    end
    cmp(c, 0, "unarmed byte");
    cmp(selected, 1'b0, "unarmed");
    i_host.desel();
    tick(5);
    i_host.sel();
    i_host.send(1, 8'hC3);
    wait_rx();
    cmp(rx_data, 8'hC3, "armed byte");
    i_host.desel();
  endtask : t_rearm

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {drive_en, four_lane_enable, tx_valid, op_start, op_done, prog_step} = '0;
    lane_mode = sfe_pkg::SFE_LANE_SINGLE;
    op_kind = sfe_pkg::SFE_OP_PROGRAM;
    {tx_data, op_addr, sec_lock} = '0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(5);
    t_idle();
    t_rx(sfe_pkg::SFE_LANE_SINGLE, 1'b0, 1, 8'hA5, 4'h2);
    t_rx(sfe_pkg::SFE_LANE_DUAL, 1'b0, 2, 8'h3C, 4'h3);
    t_rx(sfe_pkg::SFE_LANE_QUAD, 1'b1, 4, 8'h96, 4'hF);
    t_rx(sfe_pkg::SFE_LANE_QUAD, 1'b0, 1, 8'h69, 4'h2);
    t_pause();
    t_tx();
    t_ops();
    t_sec();
    t_rearm();
    complete_run();
  end
endmodule : testbench

bind sfe_front_end sfe_chk i_chk (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .lane_oe(lane_oe), .lane_mode(lane_mode), .drive_en(drive_en),
  .four_lane_enable(four_lane_enable), .selected(selected), .rx_valid(rx_valid), .op_start(op_start),
  .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .busy(busy), .op_span(op_span),
  .prog_full(prog_full));
